//--- rtl/isr_pkg.sv
/*
  Package of the instrument status reporting block: register selectors,
  field positions, reset values, command codes and carrier structs.
  Assumes a command decoder outside that issues one command per cycle.
*/
package isr_pkg;

  // ---------------------------------------------------------------
  // Register part selectors for queries and writes
  // ---------------------------------------------------------------
  localparam logic [4:0] SEL_STB = 5'h00;
  localparam logic [4:0] SEL_ESR = 5'h01;
  localparam logic [4:0] SEL_SRE = 5'h02;
  localparam logic [4:0] SEL_ESE = 5'h03;
  localparam logic [4:0] SEL_PPE = 5'h04;
  localparam logic [4:0] SEL_OPER_BASE = 5'h08;
  localparam logic [4:0] SEL_QUES_BASE = 5'h0C;
  localparam logic [4:0] SEL_QREF_BASE = 5'h10;
  localparam logic [4:0] SEL_QLIM_BASE = 5'h14;
  localparam logic [4:0] SEL_QOVL_BASE = 5'h18;
  // Part index within a group (low two bits of the selector).
  localparam logic [1:0] PART_COND = 2'h0;
  localparam logic [1:0] PART_EVENT = 2'h1;
  localparam logic [1:0] PART_ENABLE = 2'h2;
  localparam logic [1:0] PART_FILT = 2'h3; // Write: rise filter; read: rise filter.
  localparam logic [4:0] SEL_FALL_OFS = 5'h1C; // Plus group index for falling filters.

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int QREF_EXT_BIT = 8;
  localparam int QLIM_L1_BIT = 0;
  localparam int QLIM_L2_BIT = 1;
  localparam int QOVL_IF_BIT = 2;
  localparam int QUESTIONABLE_LIMIT_STATUS_BIT = 9;
  localparam int QUES_REF_BIT = 5;
  localparam int QUES_OVL_BIT = 3;
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam int ESR_OPC_BIT = 0;
  localparam logic [15:0] QREF_USED = 16'h0100;
  localparam logic [15:0] QLIM_USED = 16'h0003;
  localparam logic [15:0] QOVL_USED = 16'h0004;
  localparam logic [15:0] REG15_MASK = 16'h7FFF;
  localparam logic [7:0] SRQ_SOURCES = 8'hBC;

  // ---------------------------------------------------------------
  // Reset and preset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RISE_PRESET = 16'hFFFF;
  localparam logic [15:0] FALL_PRESET = 16'h0000;
  localparam logic [15:0] EN_PRESET_OQ = 16'h0000;
  localparam logic [15:0] EN_PRESET_SUB = 16'hFFFF;
  localparam logic [7:0] BYTE_CLEAR = 8'h00;
  localparam int ERRQ_DEPTH = 8;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_OVERFLOW = 16'hFEF2; // Queue overflow, -270.

  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_READ = 3'h2,
    CMD_CLS = 3'h3,
    CMD_PRESET = 3'h4,
    CMD_ERRQ = 3'h5,
    CMD_DCL = 3'h6,
    CMD_POWERON = 3'h7
  } isr_cmd_t;

  typedef struct packed {
    isr_cmd_t cmd;
    logic [4:0] sel;
    logic [15:0] wdata;
    logic psc;        // Power-on status clear setting.
    logic first_cmd;  // First command after a message terminator.
  } isr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } isr_rsp_t;

  typedef struct packed {
    logic ext_ref;
    logic lim1_fail;
    logic lim2_fail;
    logic if_overload;
  } isr_cond_t;

endpackage

//--- rtl/isr_status.sv
/*
  Status reporting block: questionable sub-registers, summary chain,
  status byte with service request, serial poll, queries, error queue
  and the reset events. Assumes a synchronous command decoder on clk
  and condition pins from other clock domains; oper_cond and ques_cond_in on clk.
  Limitations: the overload group has no addressable falling filter,
  and the error queue keeps only numeric codes, not message text.
  Instrument settings live elsewhere; nothing here alters them.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_status
  import isr_pkg::*;
(
  input wire logic clk,              // 100 MHz clock.
  input wire logic resetn,           // Synchronous reset, active low.
  input wire isr_cond_t cond_in,     // Raw condition levels from pins.
  input wire logic [15:0] oper_cond, // Operation conditions, same domain.
  input wire logic [15:0] ques_cond_in, // Other questionable conditions.
  input wire logic [7:0] esr_set,    // Standard event pulses.
  input wire logic err_push,         // One-cycle pulse: error state.
  input wire logic [15:0] err_code,  // Code of that error.
  input wire logic out_avail,        // Output buffer holds data.
  input wire isr_req_t req,          // Command from the decoder.
  input wire logic poll_req,         // Serial poll interface message.
  output isr_rsp_t rsp,              // Query answer.
  output logic [7:0] poll_byte,      // Serial poll answer.
  output logic poll_valid,           // Serial poll answer valid.
  output logic srq,                  // Service request.
  output logic overload_display_indicator, // Overload shown on display.
  output logic clr_out_buf,          // Pulse: clear output buffer.
  output logic clr_in_proc           // Pulse: clear input and parsing.
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] event_r;
    logic [15:0] enable;
    logic [15:0] rise;
    logic [15:0] fall;
  } isr_grp_t;

  typedef struct packed {
    logic [1:0][3:0] sync;     // Two-stage synchroniser per pin input.
    isr_grp_t [4:0] grp;       // 0 oper, 1 ques, 2 ref, 3 lim, 4 ovl.
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] ppe;
    logic [ERRQ_DEPTH-1:0][15:0] errq;
    logic [3:0] errq_cnt;
    isr_rsp_t rsp;
    logic [7:0] poll_byte;
    logic poll_valid;
    logic srq;
    logic ovl_ind;
    logic clr_out;
    logic clr_in;
  } isr_state_t;

  // One register for the whole state keeps reset and update in one
  // place; s_d is its next value.
  isr_state_t s_q, s_d;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Mask of bits that carry a function in each group.
  function automatic logic [15:0] used_mask(input int g);
    case (g)
      2: used_mask = QREF_USED;
      3: used_mask = QLIM_USED;
      4: used_mask = QOVL_USED;
      default: used_mask = REG15_MASK;
    endcase
  endfunction

  // Default enable value after a status preset.
  function automatic logic [15:0] en_preset(input int g);
    en_preset = (g < 2) ? EN_PRESET_OQ : (EN_PRESET_SUB & used_mask(g));
  endfunction

  // Summary of one group: any event bit whose enable bit is set.
  // A plain OR of the masked bits, so a summary falls again as soon as
  // the event part is read or cleared.
  function automatic logic grp_sum(input isr_grp_t g);
    grp_sum = |(g.event_r & g.enable);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] newc [5];
    logic [7:0] stb;
    logic [2:0] gi;
    logic [1:0] pi;
    newc = '{default: 16'h0000};
    stb = 8'h00;
    gi = 3'h0;
    pi = 2'h0;
    // Start from the held state; strobes below default to idle so that
    // each answer and clear pulse lasts exactly one cycle.
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.poll_valid = 1'b0;
    s_d.clr_out = 1'b0;
    s_d.clr_in = 1'b0;
    gi = 3'(req.sel[4:2] - 3'h2);
    pi = req.sel[1:0];
    // Pin levels pass two flops; only the second stage is used.
    // The first stage may still be settling, so no logic reads it; the
    // price is two cycles of latency on every condition pin.
    s_d.sync[0] = {cond_in.ext_ref, cond_in.lim1_fail, cond_in.lim2_fail,
                   cond_in.if_overload};
    s_d.sync[1] = s_q.sync[0];
    newc[2] = '0;
    newc[2][QREF_EXT_BIT] = s_q.sync[1][3];
    newc[3] = '0;
    newc[3][QLIM_L1_BIT] = s_q.sync[1][2];
    newc[3][QLIM_L2_BIT] = s_q.sync[1][1];
    newc[4] = '0;
    newc[4][QOVL_IF_BIT] = s_q.sync[1][0];
    s_d.ovl_ind = s_q.sync[1][0];
    // Operation conditions come from logic on this clock, so they need no
    // synchroniser; bit 15 is forced low.
    newc[0] = oper_cond & REG15_MASK;
    // Sub-register summaries feed the questionable conditions.
    newc[1] = ques_cond_in & REG15_MASK;
    newc[1][QUES_REF_BIT] = grp_sum(s_q.grp[2]);
    newc[1][QUESTIONABLE_LIMIT_STATUS_BIT] = grp_sum(s_q.grp[3]);
    newc[1][QUES_OVL_BIT] = grp_sum(s_q.grp[4]);
    // Transition filters set event bits; setting wins over a read-clear.
    // Unused bits are masked here so they can never reach a summary.
    for (int g = 0; g < 5; g++) begin
      s_d.grp[g].cond = newc[g] & used_mask(g);
      s_d.grp[g].event_r = s_q.grp[g].event_r
        | ((newc[g] & ~s_q.grp[g].cond & s_q.grp[g].rise)
        | (~newc[g] & s_q.grp[g].cond & s_q.grp[g].fall)) & used_mask(g);
    end
    // The status byte is assembled from the summaries each cycle.
    // Bit 6 takes the next service request value, so a poll sees the
    // request together with the bit that raised it.
    stb[STB_ERRQ_BIT] = (s_q.errq_cnt != 4'h0);
    stb[STB_QUES_BIT] = grp_sum(s_q.grp[1]);
    stb[STB_MAV_BIT] = out_avail;
    stb[STB_ESB_BIT] = |(s_q.esr & s_q.ese);
    stb[STB_OPER_BIT] = grp_sum(s_q.grp[0]);
    s_d.srq = |(stb & s_q.sre & SRQ_SOURCES);
    stb[STB_RQS_BIT] = s_d.srq;
    s_d.esr = s_q.esr | esr_set;
    // Serial poll is answered straight from the byte, no parsing.
    if (poll_req) begin
      s_d.poll_byte = stb;
      s_d.poll_valid = 1'b1;
    end
    // Error entries append; when full the last slot marks overflow.
    // Later errors are dropped so that the oldest causes survive, which
    // are usually the ones that explain the rest.
    if (err_push) begin
      if (s_q.errq_cnt < 4'(ERRQ_DEPTH - 1)) begin
        s_d.errq[s_q.errq_cnt[2:0]] = err_code;
        s_d.errq_cnt = s_q.errq_cnt + 4'h1;
      end else if (s_q.errq_cnt == 4'(ERRQ_DEPTH - 1)) begin
        s_d.errq[s_q.errq_cnt[2:0]] = ERR_OVERFLOW;
        s_d.errq_cnt = s_q.errq_cnt + 4'h1;
      end
    end
    // A new program message throws away unread answers.
    // This clear runs beside the command itself, whatever it is.
    if (req.first_cmd && req.cmd != CMD_NONE) begin
      s_d.clr_out = 1'b1;
    end
    // Command handling; none of these touch instrument settings.
    unique case (req.cmd)
      CMD_NONE: begin
      end
      CMD_WRITE: begin
        // Read-only and unmapped selectors fall through and are ignored.
        if (req.sel == SEL_SRE) begin
          s_d.sre = req.wdata[7:0];
        end else if (req.sel == SEL_ESE) begin
          s_d.ese = req.wdata[7:0];
        end else if (req.sel == SEL_PPE) begin
          s_d.ppe = req.wdata[7:0];
        end else if (req.sel >= SEL_FALL_OFS) begin
          // Only groups 0 to 3 fit in the falling-filter window.
          s_d.grp[req.sel[1:0]].fall = req.wdata & used_mask(int'(req.sel[1:0]));
        end else if (req.sel >= SEL_OPER_BASE && pi == PART_ENABLE) begin
          s_d.grp[gi].enable = req.wdata & used_mask(int'(gi));
        end else if (req.sel >= SEL_OPER_BASE && pi == PART_FILT) begin
          s_d.grp[gi].rise = req.wdata & used_mask(int'(gi));
        end
      end
      CMD_READ: begin
        // Unmapped selectors still answer, with a value of zero.
        s_d.rsp.valid = 1'b1;
        s_d.rsp.data = ERR_NONE;
        if (req.sel == SEL_STB) begin
          s_d.rsp.data = {8'h00, stb};
        end else if (req.sel == SEL_ESR) begin
          s_d.rsp.data = {8'h00, s_q.esr};
          s_d.esr = esr_set;
        end else if (req.sel == SEL_SRE) begin
          s_d.rsp.data = {8'h00, s_q.sre};
        end else if (req.sel == SEL_ESE) begin
          s_d.rsp.data = {8'h00, s_q.ese};
        end else if (req.sel == SEL_PPE) begin
          s_d.rsp.data = {8'h00, s_q.ppe};
        end else if (req.sel >= SEL_FALL_OFS) begin
          s_d.rsp.data = s_q.grp[req.sel[1:0]].fall;
        end else if (req.sel >= SEL_OPER_BASE) begin
          unique case (pi)
            PART_COND: s_d.rsp.data = s_q.grp[gi].cond;
            PART_EVENT: begin
              s_d.rsp.data = s_q.grp[gi].event_r;
              s_d.grp[gi].event_r = s_d.grp[gi].event_r & ~s_q.grp[gi].event_r;
            end
            PART_ENABLE: s_d.rsp.data = s_q.grp[gi].enable;
            PART_FILT: s_d.rsp.data = s_q.grp[gi].rise;
          endcase
        end
      end
      CMD_ERRQ: begin
        // The oldest entry leaves first; a push in the same cycle lands
        // behind the shifted entries; with 7 or 8 queued it becomes the overflow mark or is dropped.
        s_d.rsp.valid = 1'b1;
        s_d.rsp.data = (s_q.errq_cnt == 4'h0) ? ERR_NONE : s_q.errq[0];
        if (s_q.errq_cnt != 4'h0) begin
          for (int i = 0; i < ERRQ_DEPTH - 1; i++) begin
            s_d.errq[i] = s_d.errq[i + 1];
          end
          s_d.errq_cnt = s_d.errq_cnt - 4'h1;
        end
      end
      CMD_CLS: begin
        // Clear wins only over old contents: an event or error arriving in
        // this very cycle is kept, so nothing is lost across the clear.
        s_d.esr = esr_set;
        s_d.errq_cnt = {3'h0, err_push};
        s_d.errq[0] = err_code;
        for (int g = 0; g < 5; g++) begin
          s_d.grp[g].event_r = s_d.grp[g].event_r & ~s_q.grp[g].event_r;
        end
      end
      CMD_PRESET: begin
        // Filters and enables only; events and the queue are untouched,
        // so a pending cause stays in its event part, though the zeroed oper and ques enables drop it from the status byte.
        for (int g = 0; g < 5; g++) begin
          s_d.grp[g].rise = RISE_PRESET & used_mask(g);
          s_d.grp[g].fall = FALL_PRESET;
          s_d.grp[g].enable = en_preset(g);
        end
      end
      CMD_DCL: begin
        // Only the buffers and the parser restart; all status stays, so
        // the controller can still find out what went wrong.
        s_d.clr_out = 1'b1;
        s_d.clr_in = 1'b1;
      end
      CMD_POWERON: begin
        // The queue and buffers always clear; the status parts only when
        // the power-on status clear setting asks for it.
        s_d.errq_cnt = 4'h0;
        s_d.clr_out = 1'b1;
        s_d.clr_in = 1'b1;
        if (req.psc) begin
          s_d.esr = BYTE_CLEAR;
          s_d.sre = BYTE_CLEAR;
          s_d.ese = BYTE_CLEAR;
          s_d.ppe = BYTE_CLEAR;
          s_d.srq = 1'b0;
          for (int g = 0; g < 5; g++) begin
            s_d.grp[g].event_r = s_d.grp[g].event_r & ~s_q.grp[g].event_r;
            s_d.grp[g].enable = en_preset(g);
            s_d.grp[g].rise = RISE_PRESET & used_mask(g);
            s_d.grp[g].fall = FALL_PRESET;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset acts like a power-up with the status clear setting at 1.
  // Only constants are loaded here; the clear pulses are held high
  // through reset so the buffers outside start empty as well.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      for (int g = 0; g < 5; g++) begin
        s_q.grp[g].rise <= RISE_PRESET & used_mask(g);
        s_q.grp[g].enable <= en_preset(g);
      end
      s_q.clr_out <= 1'b1;
      s_q.clr_in <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Outputs come straight from the state flops.
  assign rsp = s_q.rsp;
  assign poll_byte = s_q.poll_byte;
  assign poll_valid = s_q.poll_valid;
  assign srq = s_q.srq;
  assign overload_display_indicator = s_q.ovl_ind;
  assign clr_out_buf = s_q.clr_out;
  assign clr_in_proc = s_q.clr_in;

endmodule
`default_nettype wire

//--- tb/isr_ctrl_model.sv
/*
  Controller side output buffer: holds answers until the block clears it.
  Assumes the block's answer and clear strobes are one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model
  import isr_pkg::*;
(
  input wire logic clk, // Block clock.
  input wire logic resetn, // Reset, active low.
  input wire isr_rsp_t rsp, // Answer from the block.
  input wire logic clr_out_buf, // Clear from the block.
  output logic out_avail // Buffer holds unread data.
);
  // Answers stay unread, so only a clear or reset empties the buffer.
  always_ff @(posedge clk) begin
    if (!resetn || clr_out_buf) begin
      out_avail <= 1'b0;
    end else if (rsp.valid) begin
      out_avail <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/isr_status_props.sv
/*
  Port checker of the status reporting block.
  Assumes it is bound to isr_status and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_status_props
  import isr_pkg::*;
(
  input wire logic clk, // Block clock.
  input wire logic resetn, // Reset, active low.
  input wire isr_cond_t cond_in, // Condition pins.
  input wire isr_req_t req, // Command in.
  input wire logic poll_req, // Serial poll request.
  input wire isr_rsp_t rsp, // Query answer.
  input wire logic poll_valid, // Poll answer strobe.
  input wire logic overload_display_indicator, // Overload shown.
  input wire logic clr_out_buf, // Output buffer clear.
  input wire logic clr_in_proc // Input and parser clear.
);
  // All checks pause while reset is low.
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  read_answer_a: assert property (req.cmd == CMD_READ |=> rsp.valid)
    else $error("read got no answer");
  errq_answer_a: assert property (req.cmd == CMD_ERRQ |=> rsp.valid)
    else $error("error query got no answer");
  answer_cause_a: assert property (rsp.valid |-> $past(req.cmd) inside {CMD_READ, CMD_ERRQ})
    else $error("answer without a query");
  poll_answer_a: assert property (poll_req |=> poll_valid)
    else $error("poll got no answer");
  poll_cause_a: assert property (poll_valid |-> $past(poll_req))
    else $error("poll answer without poll");
  dev_clear_a: assert property (req.cmd == CMD_DCL |=> clr_out_buf && clr_in_proc)
    else $error("device clear missed a buffer");
  power_clear_a: assert property (req.cmd == CMD_POWERON |=> clr_out_buf && clr_in_proc)
    else $error("power-on missed a buffer");
  // The first cycles after reset may carry the reset's own clear pulse.
  in_clear_cause_a: assert property (clr_in_proc && $past(resetn, 2) |->
    $past(req.cmd) inside {CMD_DCL, CMD_POWERON})
    else $error("input cleared without cause");
  first_cmd_clear_a: assert property (req.cmd != CMD_NONE && req.first_cmd |=> clr_out_buf)
    else $error("first command kept output");
  overload_on_a: assert property (cond_in.if_overload [*6] |-> overload_display_indicator)
    else $error("overload not shown");
  overload_off_a: assert property (!cond_in.if_overload [*6] |-> !overload_display_indicator)
    else $error("overload shown while clear");
endmodule
`default_nettype wire

//--- tb/isr_status_test.sv
/*
  Self-checking bench of the status reporting block.
  Assumes the one-cycle answer latency of the block's command port.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_status_test;
  import isr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  isr_cond_t cond_in = '0;
  logic [7:0] esr_set = 8'h00;
  logic err_push = 1'b0;
  logic [15:0] err_code = 16'h0000;
  isr_req_t req = '0;
  logic [15:0] oper_cond = 16'h0000;
  logic [15:0] ques_cond = 16'h0000;
  logic poll_req = 1'b0;
  logic out_avail, poll_valid, srq, ovl_ind, clr_ob, clr_ip;
  isr_rsp_t rsp;
  logic [7:0] poll_byte;
  int num_errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  isr_status dut_u (.clk(clk), .resetn(resetn), .cond_in(cond_in), .oper_cond(oper_cond),
    .ques_cond_in(ques_cond), .esr_set(esr_set), .err_push(err_push), .err_code(err_code),
    .out_avail(out_avail), .req(req), .poll_req(poll_req), .rsp(rsp), .poll_byte(poll_byte),
    .poll_valid(poll_valid), .srq(srq), .overload_display_indicator(ovl_ind),
    .clr_out_buf(clr_ob), .clr_in_proc(clr_ip));
  isr_ctrl_model ctrl_u (.clk(clk), .resetn(resetn), .rsp(rsp), .clr_out_buf(clr_ob),
    .out_avail(out_avail));

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One command, held until the edge that takes it; answers land one cycle later.
  task automatic op(input isr_cmd_t c, input logic [4:0] s, input logic [15:0] w,
    input logic p);
    @(posedge clk);
    #1 req = '{cmd: c, sel: s, wdata: w, psc: p, first_cmd: 1'b0};
    @(posedge clk);
    #1 req.cmd = CMD_NONE;
  endtask

  task automatic rd(input logic [4:0] s, input logic [15:0] exp);
    op(CMD_READ, s, 16'h0000, 1'b0);
    chk("read valid", {15'h0000, rsp.valid}, 16'h0001);
    chk($sformatf("read sel %h", s), rsp.data, exp);
  endtask

  task automatic erq(input logic [15:0] exp);
    op(CMD_ERRQ, 5'h00, 16'h0000, 1'b0);
    chk("error entry", rsp.data, exp);
  endtask

  task automatic push(input logic [15:0] c);
    @(posedge clk);
    #1 err_push = 1'b1;
    err_code = c;
    @(posedge clk);
    #1 err_push = 1'b0;
  endtask

  // Bounded wait: a service request that never settles ends the run.
  task automatic wait_srq(input logic e);
    for (int i = 0; i < 10 && srq !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk("srq", {15'h0000, srq}, {15'h0000, e});
    if (srq !== e) test_done();
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(SEL_QREF_BASE + 5'h02, QREF_USED);
    rd(SEL_QLIM_BASE + 5'h03, QLIM_USED);
    rd(SEL_FALL_OFS + 5'h03, 16'h0000);
    rd(SEL_OPER_BASE + 5'h02, 16'h0000);
    rd(SEL_SRE, 16'h0000);
    chk("no first clear", {15'h0000, clr_ob}, 16'h0000);
    $display("test reset values done");
    cond_in = '{ext_ref: 1'b1, lim1_fail: 1'b1, lim2_fail: 1'b1, if_overload: 1'b1};
    settle();
    chk("indicator", {15'h0000, ovl_ind}, 16'h0001);
    rd(SEL_QREF_BASE, 16'h0100);
    rd(SEL_QLIM_BASE, 16'h0003);
    rd(SEL_QOVL_BASE, 16'h0004);
    rd(SEL_QLIM_BASE + 5'h01, 16'h0003);
    rd(SEL_QLIM_BASE + 5'h01, 16'h0000);
    rd(SEL_QLIM_BASE, 16'h0003);
    op(CMD_WRITE, SEL_FALL_OFS + 5'h03, 16'hFFFF, 1'b0);
    op(CMD_WRITE, SEL_QOVL_BASE + 5'h02, 16'hFFFF, 1'b0);
    rd(SEL_QOVL_BASE + 5'h02, 16'h0004);
    cond_in = '0;
    settle();
    rd(SEL_QLIM_BASE + 5'h01, 16'h0003);
    $display("test questionable parts done");
    op(CMD_WRITE, SEL_SRE, 16'h0020, 1'b0);
    op(CMD_WRITE, SEL_ESE, 16'h0001, 1'b0);
    @(posedge clk);
    #1 esr_set = 8'h01;
    @(posedge clk);
    #1 esr_set = 8'h00;
    wait_srq(1'b1);
    @(posedge clk);
    #1 poll_req = 1'b1;
    @(posedge clk);
    #1 poll_req = 1'b0;
    chk("poll valid", {15'h0000, poll_valid}, 16'h0001);
    chk("poll bits", {8'h00, poll_byte & 8'h60}, 16'h0060);
    op(CMD_CLS, 5'h00, 16'h0000, 1'b0);
    wait_srq(1'b0);
    rd(SEL_SRE, 16'h0020);
    $display("test service request done");
    push(16'hFF9C);
    push(16'h0101);
    erq(16'hFF9C);
    erq(16'h0101);
    erq(ERR_NONE);
    push(16'h0102);
    op(CMD_CLS, 5'h00, 16'h0000, 1'b0);
    erq(ERR_NONE);
    $display("test error queue done");
    op(CMD_WRITE, SEL_QUES_BASE + 5'h02, 16'hFFFF, 1'b0);
    op(CMD_WRITE, SEL_QREF_BASE + 5'h03, 16'h0000, 1'b0);
    op(CMD_PRESET, 5'h00, 16'h0000, 1'b0);
    rd(SEL_QUES_BASE + 5'h02, 16'h0000);
    rd(SEL_QREF_BASE + 5'h03, QREF_USED);
    rd(SEL_SRE, 16'h0020);
    $display("test status preset done");
    op(CMD_DCL, 5'h00, 16'h0000, 1'b0);
    chk("input clear", {15'h0000, clr_ip}, 16'h0001);
    rd(SEL_SRE, 16'h0020);
    @(posedge clk);
    #1 req = '{cmd: CMD_READ, sel: SEL_SRE, wdata: 16'h0000, psc: 1'b0, first_cmd: 1'b1};
    @(posedge clk);
    #1 req = '0;
    chk("first clear", {15'h0000, clr_ob}, 16'h0001);
    push(16'h0103);
    op(CMD_POWERON, 5'h00, 16'h0000, 1'b0);
    rd(SEL_SRE, 16'h0020);
    erq(ERR_NONE);
    op(CMD_POWERON, 5'h00, 16'h0000, 1'b1);
    rd(SEL_SRE, 16'h0000);
    $display("test clear events done");
    oper_cond = 16'h0001;
    op(CMD_WRITE, SEL_OPER_BASE + 5'h02, 16'h0001, 1'b0);
    op(CMD_WRITE, SEL_SRE, 16'h0080, 1'b0);
    wait_srq(1'b1);
    rd(SEL_OPER_BASE + 5'h01, 16'h0001);
    wait_srq(1'b0);
    cond_in = '{ext_ref: 1'b1, lim1_fail: 1'b0, lim2_fail: 1'b0, if_overload: 1'b0};
    op(CMD_WRITE, SEL_QUES_BASE + 5'h02, 16'h0030, 1'b0);
    op(CMD_WRITE, SEL_SRE, 16'h0008, 1'b0);
    wait_srq(1'b1);
    ques_cond = 16'h0010;
    settle();
    rd(SEL_QUES_BASE, 16'h0030);
    rd(SEL_QUES_BASE + 5'h01, 16'h0030);
    wait_srq(1'b0);
    $display("test summary chain done");
    test_done();
  end
endmodule

bind isr_status isr_status_props props_u (.clk(clk), .resetn(resetn), .cond_in(cond_in),
  .req(req), .poll_req(poll_req), .rsp(rsp), .poll_valid(poll_valid),
  .overload_display_indicator(overload_display_indicator), .clr_out_buf(clr_out_buf),
  .clr_in_proc(clr_in_proc));
`default_nettype wire
